//--- hw/acm_pkg.sv
// shared constants and types of the conversion mode controller
package acm_pkg;

  // ==========================================================================
  // clocks and times
  localparam longint ACM_CLK_KHZ    = 100000;
  localparam longint ACM_OSC_KHZ    = 512;
  localparam longint ACM_WAKE_NS    = 25000;
  localparam longint ACM_WAKE_CYC   = (ACM_WAKE_NS * ACM_CLK_KHZ + 999999) / 1000000;
  localparam longint ACM_DROP_NS    = 8000;
  localparam longint ACM_DROP_RAW   = (ACM_DROP_NS * ACM_OSC_KHZ) / 1000000;
  localparam longint ACM_DROP_TICKS = (ACM_DROP_RAW < 1) ? 1 : ACM_DROP_RAW;

  // ==========================================================================
  // settings register
  localparam logic [3:0]  ACM_CFG_INDEX   = 4'h1;
  localparam logic [15:0] ACM_CFG_RESET   = 16'h058b;
  localparam int          ACM_TRIG_BIT    = 15;
  localparam int          ACM_MUX_LSB     = 12;
  localparam int          ACM_PGA_LSB     = 9;
  localparam int          ACM_MODE_BIT    = 8;
  localparam int          ACM_RATE_LSB    = 5;
  localparam int          ACM_PULLUP_BIT  = 3;
  localparam int          ACM_WSEQ_LSB    = 1;
  localparam logic [1:0]  ACM_WSEQ_VALID  = 2'h1;

  // ==========================================================================
  // input select codes
  localparam logic [2:0] ACM_MUX_D01 = 3'h0;
  localparam logic [2:0] ACM_MUX_D03 = 3'h1;
  localparam logic [2:0] ACM_MUX_D13 = 3'h2;
  localparam logic [2:0] ACM_MUX_D23 = 3'h3;
  localparam logic [2:0] ACM_MUX_S0  = 3'h4;
  localparam logic [2:0] ACM_MUX_S1  = 3'h5;
  localparam logic [2:0] ACM_MUX_S2  = 3'h6;
  localparam logic [2:0] ACM_MUX_S3  = 3'h7;

  // ==========================================================================
  // full-scale ranges in microvolts, code 7 repeats the narrowest range
  localparam logic [22:0] ACM_FSR_UV [0:7] = '{23'h5dc000, 23'h3e8000, 23'h1f4000,
                                               23'h0fa000, 23'h07d000, 23'h03e800,
                                               23'h00fa00, 23'h00fa00};
  // oscillator ticks per conversion, 6.25 up to 1000 samples per second
  localparam logic [16:0] ACM_CONV_TICKS [0:7] = '{17'h14000, 17'h0a000, 17'h05000,
                                                   17'h02800, 17'h01400, 17'h00800,
                                                   17'h00400, 17'h00200};

  // ==========================================================================
  // result and frame
  localparam logic [23:0] ACM_POS_FULL   = 24'h7fffff;
  localparam logic [23:0] ACM_NEG_FULL   = 24'h800000;
  localparam logic [5:0]  ACM_DIN_LAST   = 6'h17;
  localparam logic [5:0]  ACM_DIV_LAST   = 6'h2f;

  typedef enum logic [1:0] {ACM_OFF, ACM_WAKE, ACM_CONV} acm_state_t;

endpackage

//--- hw/acm_div.sv
// sequential divider that scales a differential input to a result code
`timescale 1ns/1ps
module acm_div
  import acm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [47:0] numer,
  input  wire logic [22:0] denom,
  output logic             busy,
  output logic             done,
  output logic [47:0]      quot
);

  logic [22:0] rem_q;
  logic [47:0] quo_q;
  logic [22:0] den_q;
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic        done_q;

  // ==========================================================================
  // restoring step, one quotient bit per clock
  wire logic [23:0] shifted = {rem_q, quo_q[47]};
  wire logic [24:0] trial   = {1'b0, shifted} - {2'h0, den_q};
  wire logic        fits    = ~trial[24];

  always_ff @(posedge clk) begin
    if (reset) begin
      rem_q  <= 23'h0;
      quo_q  <= 48'h0;
      den_q  <= 23'h0;
      cnt_q  <= 6'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start && !busy_q) begin
      rem_q  <= 23'h0;
      quo_q  <= numer;
      den_q  <= denom;
      cnt_q  <= 6'h0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && (cnt_q == ACM_DIV_LAST);
      if (busy_q) begin
        rem_q  <= fits ? trial[22:0] : shifted[22:0];
        quo_q  <= {quo_q[46:0], fits};
        cnt_q  <= cnt_q + 6'h1;
        busy_q <= (cnt_q != ACM_DIV_LAST);
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign quot = quo_q;

  // ==========================================================================
  // checks
  property p_div_len;
    @(posedge clk) disable iff (reset)
      (start && !busy_q) |-> ##49 done_q;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide did not take 48 steps");

endmodule

//--- hw/acm_link.sv
// serial clock side of the port: shifts results out and settings in
`timescale 1ns/1ps
module acm_link
  import acm_pkg::*;
(
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic [39:0] snap_word,
  output logic             dout_bit,
  output logic             started,
  output logic             wr_pend,
  output logic [15:0]      wr_word
);

  logic [47:0] out_sh_q;
  logic        started_q;
  logic [22:0] in_sh_q;
  logic [5:0]  fall_cnt_q;
  logic        wr_pend_q;
  logic [15:0] wr_word_q;

  // ==========================================================================
  // output side, chip select high clears the frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_sh_q  <= 48'h0;
      started_q <= 1'b0;
    end else if (!started_q) begin
      // result is locked for the whole frame
      out_sh_q  <= {snap_word[39:16], 8'h00, snap_word[15:0]};
      started_q <= 1'b1;
    end else begin
      out_sh_q  <= {out_sh_q[46:0], 1'b0};
    end
  end

  // ==========================================================================
  // input side
  wire logic [15:0] in_word  = {in_sh_q[14:0], din};
  wire logic        in_last  = (fall_cnt_q == ACM_DIN_LAST);
  wire logic        in_valid = (in_word[ACM_WSEQ_LSB +: 2] == ACM_WSEQ_VALID);

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      in_sh_q    <= 23'h0;
      fall_cnt_q <= 6'h0;
      wr_pend_q  <= 1'b0;
    end else begin
      in_sh_q <= {in_sh_q[21:0], din};
      // count parks one past the last data edge, so later bits never rewrite the word
      if (fall_cnt_q <= ACM_DIN_LAST) begin
        fall_cnt_q <= fall_cnt_q + 6'h1;
      end
      if (in_last && in_valid) begin
        wr_pend_q <= 1'b1;
      end
    end
  end

  // held across the frame end so the system side can still take it
  always_ff @(negedge sclk) begin
    if (!cs_n && in_last && in_valid) begin
      wr_word_q <= in_word;
    end
  end

  assign dout_bit = out_sh_q[47];
  assign started  = started_q;
  assign wr_pend  = wr_pend_q;
  assign wr_word  = wr_word_q;

endmodule

//--- hw/acm_ctl.sv
// conversion mode controller of a 24-bit delta-sigma converter
//
// Overview of operation
// - three-bit input select picks single, differential or fourth-input referenced pair
// - single-ended selections ground the negative input; no negative codes result
// - three-bit gain field picks one of seven full-scale ranges
// - one code step equals the full-scale span over two to the 24th
// - conversion timing comes from a 512 kHz internal oscillator; the 25 us wake time is counted in clk cycles
// - three-bit rate field picks one of eight output data rates
// - a conversion takes exactly one data-rate period
// - reset loads the settings word with 058b
// - after reset the converter idles powered down, interface alive
// - mode bit one means single-shot, powered down between conversions
// - settings writes are accepted while powered down
// - trigger write powers up in 25 us, clears trigger, converts once
// - trigger writes during a running conversion are ignored
// - mode bit zero converts back to back, storing every result
// - select, gain and rate changes apply only from the next conversion; pull-up and mode bits apply at once
// - writing mode one or reset ends continuous conversion
// - results are two's complement and saturate at both full scales
// - serial input is sampled on falling serial clock edges
// - serial output changes on rising serial clock edges
// - shared output pin goes low while chip select is low and a new result is ready
`timescale 1ns/1ps
module acm_ctl
  import acm_pkg::*;
#(
  parameter int unsigned OSC_STEP_KHZ = 512
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic [23:0] analog_input_first,
  input  wire logic [23:0] analog_input_second,
  input  wire logic [23:0] analog_input_third,
  input  wire logic [23:0] analog_input_fourth,
  output logic             serial_out_ready_pin,
  output logic             serial_out_ready_pin_oe_n,
  output logic             pull_up_en,
  output logic             converter_awake
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // analog input capture, levels from outside pass two stages
  wire logic [23:0] ain_raw [4];
  logic      [23:0] ain_meta_q [4];
  logic      [23:0] ain_q [4];

  assign ain_raw[0] = analog_input_first;
  assign ain_raw[1] = analog_input_second;
  assign ain_raw[2] = analog_input_third;
  assign ain_raw[3] = analog_input_fourth;

  for (genvar i = 0; i < 4; i++) begin : g_ain
    always_ff @(posedge clk) begin
      if (reset) begin
        ain_meta_q[i] <= 24'h0;
        ain_q[i]      <= 24'h0;
      end else begin
        ain_meta_q[i] <= ain_raw[i];
        ain_q[i]      <= ain_meta_q[i];
      end
    end
  end

  // ==========================================================================
  // link crossing: chip select, frame start and write pending levels
  logic        link_dout;
  logic        link_started;
  logic        link_pend;
  logic [15:0] link_word;
  logic [39:0] snap_q;
  logic [2:0]  sync_meta_q;
  logic [2:0]  sync_q;
  logic        st_prev_q;
  logic        pd_prev_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_meta_q <= 3'h1;
      sync_q      <= 3'h1;
      st_prev_q   <= 1'b0;
      pd_prev_q   <= 1'b0;
    end else begin
      sync_meta_q <= {link_pend, link_started, cs_n};
      sync_q      <= sync_meta_q;
      st_prev_q   <= sync_q[1];
      pd_prev_q   <= sync_q[2];
    end
  end

  wire logic cs_s    = sync_q[0];
  wire logic st_rise = sync_q[1] & ~st_prev_q;
  wire logic wr_take = sync_q[2] & ~pd_prev_q;

  acm_link u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .din       (din),
    .snap_word (snap_q),
    .dout_bit  (link_dout),
    .started   (link_started),
    .wr_pend   (link_pend),
    .wr_word   (link_word)
  );

  // ==========================================================================
  // internal oscillator as a fractional divider of clk
  logic [16:0] osc_acc_q;

  wire logic [17:0] osc_sum  = {1'b0, osc_acc_q} + 18'(OSC_STEP_KHZ);
  wire logic        osc_tick = (osc_sum >= 18'(ACM_CLK_KHZ));
  wire logic [17:0] osc_wrap = osc_sum - 18'(ACM_CLK_KHZ);
  wire logic [16:0] osc_d    = osc_tick ? osc_wrap[16:0] : osc_sum[16:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      osc_acc_q <= 17'h0;
    end else begin
      osc_acc_q <= osc_d;
    end
  end

  // ==========================================================================
  // settings register and sequencer
  acm_state_t  state_q;
  acm_state_t  state_d;
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [11:0] wake_cnt_q;
  logic [16:0] tick_cnt_q;
  logic [2:0]  act_mux_q;
  logic [2:0]  act_pga_q;
  logic [2:0]  act_rate_q;

  wire logic        cfg_mode   = cfg_q[ACM_MODE_BIT];
  wire logic        cfg_trig   = cfg_q[ACM_TRIG_BIT];
  wire logic        wake_done  = (wake_cnt_q == 12'(ACM_WAKE_CYC - 1));
  wire logic        in_wake    = (state_q == ACM_WAKE);
  wire logic        in_conv    = (state_q == ACM_CONV);
  wire logic [16:0] conv_len   = ACM_CONV_TICKS[act_rate_q];
  wire logic [16:0] conv_left  = conv_len - tick_cnt_q;
  wire logic        conv_end   = in_conv && osc_tick && (conv_left == 17'h1);
  wire logic        trig_clear = in_wake && wake_done;
  wire logic        act_load   = trig_clear || (conv_end && !cfg_mode);

  always_comb begin
    cfg_d = cfg_q;
    if (trig_clear) begin
      cfg_d[ACM_TRIG_BIT] = 1'b0;
    end
    if (wr_take) begin
      cfg_d = link_word;
      // trigger only counts while nothing is running
      cfg_d[ACM_TRIG_BIT] = link_word[ACM_TRIG_BIT] & (state_q == ACM_OFF);
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ACM_OFF: begin
        if (cfg_trig || !cfg_mode) begin
          state_d = ACM_WAKE;
        end
      end
      ACM_WAKE: begin
        if (wake_done) begin
          state_d = ACM_CONV;
        end
      end
      ACM_CONV: begin
        if (conv_end && cfg_mode) begin
          state_d = ACM_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ACM_OFF;
      cfg_q   <= ACM_CFG_RESET;
    end else begin
      state_q <= state_d;
      cfg_q   <= cfg_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_cnt_q <= 12'h0;
      tick_cnt_q <= 17'h0;
    end else begin
      wake_cnt_q <= in_wake ? wake_cnt_q + 12'h1 : 12'h0;
      if (!in_conv || conv_end) begin
        tick_cnt_q <= 17'h0;
      end else if (osc_tick) begin
        tick_cnt_q <= tick_cnt_q + 17'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      act_mux_q <= ACM_CFG_RESET[ACM_MUX_LSB +: 3];
      act_pga_q <= ACM_CFG_RESET[ACM_PGA_LSB +: 3];
      act_rate_q <= ACM_CFG_RESET[ACM_RATE_LSB +: 3];
    end else if (act_load) begin
      act_mux_q <= cfg_q[ACM_MUX_LSB +: 3];
      act_pga_q <= cfg_q[ACM_PGA_LSB +: 3];
      act_rate_q <= cfg_q[ACM_RATE_LSB +: 3];
    end
  end

  // ==========================================================================
  // input routing and range scaling
  wire logic se_sel = act_mux_q[2];
  wire logic [23:0] sel_p =
    (act_mux_q == ACM_MUX_D01 || act_mux_q == ACM_MUX_D03) ? ain_q[0] :
    (act_mux_q == ACM_MUX_D13 || act_mux_q == ACM_MUX_S1)  ? ain_q[1] :
    (act_mux_q == ACM_MUX_D23 || act_mux_q == ACM_MUX_S2)  ? ain_q[2] :
    (act_mux_q == ACM_MUX_S0)                              ? ain_q[0] : ain_q[3];
  // single-ended: negative side switched to ground
  wire logic [23:0] sel_n =
    (act_mux_q == ACM_MUX_D01) ? ain_q[1] :
    se_sel                     ? 24'h0    : ain_q[3];
  wire logic [24:0] diff  = {sel_p[23], sel_p} - {sel_n[23], sel_n};
  wire logic        neg   = diff[24];
  wire logic [24:0] mag   = neg ? (25'h0 - diff) : diff;
  wire logic [47:0] numer = {mag, 23'h0};
  wire logic [22:0] denom = ACM_FSR_UV[act_pga_q];

  logic        div_busy;
  logic        div_done;
  logic [47:0] quot;
  logic        neg_q;
  logic        se_q;

  acm_div u_div (
    .clk   (clk),
    .reset (reset),
    .start (conv_end),
    .numer (numer),
    .denom (denom),
    .busy  (div_busy),
    .done  (div_done),
    .quot  (quot)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      neg_q <= 1'b0;
      se_q  <= 1'b0;
    end else if (conv_end) begin
      neg_q <= neg;
      se_q  <= se_sel;
    end
  end

  // ==========================================================================
  // result store and data ready
  logic [23:0] result_q;
  logic        rdy_q;

  wire logic        sat      = |quot[47:23];
  wire logic [23:0] code_pos = sat ? ACM_POS_FULL : quot[23:0];
  wire logic [23:0] code_neg = sat ? ACM_NEG_FULL : (24'h0 - quot[23:0]);
  wire logic [23:0] code     = (se_q && neg_q) ? 24'h0 :
                               neg_q           ? code_neg : code_pos;
  // unread data is withdrawn shortly before the next result in continuous mode
  wire logic early_drop = in_conv && !cfg_mode && (conv_left <= 17'(ACM_DROP_TICKS));
  wire logic rdy_d      = div_done | (rdy_q & ~(st_rise | early_drop));

  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= 24'h0;
      rdy_q    <= 1'b0;
    end else begin
      if (div_done) begin
        result_q <= code;
      end
      rdy_q <= rdy_d;
    end
  end

  // snapshot frozen while a frame is open, so the link reads a steady word
  always_ff @(posedge clk) begin
    if (reset) begin
      snap_q <= {24'h0, ACM_CFG_RESET};
    end else if (cs_s) begin
      snap_q <= {result_q, cfg_q};
    end
  end

  // ==========================================================================
  // pins
  assign serial_out_ready_pin      = link_started ? link_dout : ~rdy_q;
  assign serial_out_ready_pin_oe_n = cs_s;
  assign pull_up_en                = cfg_q[ACM_PULLUP_BIT];
  assign converter_awake           = (state_q != ACM_OFF);

  // ==========================================================================
  // checks
  property p_reset_idle;
    @(posedge clk) disable iff (1'b0)
      reset |=> (cfg_q == ACM_CFG_RESET) && (state_q == ACM_OFF) && !converter_awake;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset did not idle");

  property p_trig_ignored;
    (wr_take && (state_q != ACM_OFF)) |=> !cfg_q[ACM_TRIG_BIT];
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger taken while busy");

  property p_wake_len;
    (in_conv && $past(in_wake)) |-> ($past(wake_cnt_q) == 12'(ACM_WAKE_CYC - 1));
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake time wrong");

  property p_trig_clear;
    (in_wake && wake_done && !wr_take) |=> in_conv && !cfg_q[ACM_TRIG_BIT];
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

  property p_single_off;
    (conv_end && cfg_mode && !wr_take) |=> (state_q == ACM_OFF) ##1 !converter_awake
      ##1 (!converter_awake || $past(wr_take, 2));
  endproperty
  a_single_off: assert property (p_single_off) else $error("single shot kept running");

  property p_cont_next;
    (conv_end && !cfg_mode) |=> in_conv && (tick_cnt_q == 17'h0);
  endproperty
  a_cont_next: assert property (p_cont_next) else $error("continuous did not restart");

  property p_cfg_held;
    (in_conv && !$past(act_load)) |-> $stable(act_rate_q) && $stable(act_pga_q);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("settings changed mid conversion");

  property p_conv_len;
    conv_end |-> (tick_cnt_q == conv_len - 17'h1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_se_nonneg;
    (div_done && se_q) |=> !result_q[23];
  endproperty
  a_se_nonneg: assert property (p_se_nonneg) else $error("negative single-ended code");

  property p_rdy_low;
    div_done |=> rdy_q && (link_started || !serial_out_ready_pin);
  endproperty
  a_rdy_low: assert property (p_rdy_low) else $error("data ready not shown");

endmodule

//--- test/acm_host.sv
// host model that runs frames on the serial port
`timescale 1ns/1ps
module acm_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // ==========================================================================
  // frame engine
  // serial clock runs only inside a frame and idles low
  // a real rising edge of chip select clears the link flops before any frame
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    din  = 1'b0;
    #1;
    cs_n = 1'b1;
  end

  // 24 bits written, 48 read; ready sampled before the first rising edge
  task automatic xfer(input logic [23:0] w, output logic [47:0] r, output logic rdy);
    cs_n = 1'b0;
    #50;
    rdy = dout;
    for (int i = 47; i >= 0; i--) begin
      sclk = 1'b1;
      din  = (i >= 24) ? w[i-24] : 1'b0;
      #15;
      r[i] = dout;
      sclk = 1'b0;
      #15;
    end
    #50;
    cs_n = 1'b1;
    // released line: show the opposite level, never a stale bit
    din  = ~din;
    #60;
  endtask
endmodule

//--- test/acm_ctl_test.sv
// self-checking bench of the conversion mode controller
`timescale 1ns/1ps
module acm_ctl_test;
  import acm_pkg::*;
  // fast oscillator step keeps conversions short
  localparam int unsigned STEP = 65536;
  logic        clk, reset, sclk, cs_n, din, pin, oe_n, pull_up_en, awake, tgl;
  logic [23:0] a1, a2, a3, a4;
  logic [47:0] rd;
  logic        rdy;
  logic [29:0] tbl [12];
  int          fail_count, n_tests, cyc, run, n, ex;
  // released pin: pull-up level, else a changing pattern
  wire         dout = oe_n ? (pull_up_en | tgl) : pin;

  acm_ctl #(.OSC_STEP_KHZ(STEP)) acm_ctl_inst (.clk(clk), .reset(reset), .sclk(sclk),
    .cs_n(cs_n), .din(din), .analog_input_first(a1), .analog_input_second(a2),
    .analog_input_third(a3), .analog_input_fourth(a4), .serial_out_ready_pin(pin),
    .serial_out_ready_pin_oe_n(oe_n), .pull_up_en(pull_up_en), .converter_awake(awake));
  acm_host acm_host_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // ==========================================================================
  // clock, timeout, awake run length
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tgl <= ~tgl;
    run <= awake ? run + 1 : 0;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      wrap_up;
    end
  end

  // ==========================================================================
  // tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [15:0] cfg(logic t, logic [2:0] mx, logic [2:0] g, logic md,
                                      logic [2:0] r);
    return {t, mx, g, md, r, 1'b0, 1'b1, 2'h1, 1'b0};
  endfunction
  task automatic frame(input logic [15:0] w);
    @(posedge clk);
    #3;
    acm_host_inst.xfer({8'h00, w}, rd, rdy);
  endtask
  // length of the last awake run, bounded wait
  task automatic wait_done(output int k);
    k = 0;
    while (awake === 1'b1 && cyc < 89000) begin
      k = run;
      @(posedge clk);
    end
    repeat (80) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    reset = 1'b1;
    tgl = 1'b0;
    run = 0;
    cyc = 0;
    fail_count = 0;
    n_tests = 0;
    a1 = 24'd768000;
    a2 = -24'sd512000;
    a3 = 24'd256000;
    a4 = -24'sd256000;
    tbl = '{{3'h0, 3'h2, 24'h500000}, {3'h1, 3'h2, 24'h400000}, {3'h2, 3'h2, 24'hf00000},
            {3'h3, 3'h2, 24'h200000}, {3'h4, 3'h2, 24'h300000}, {3'h5, 3'h2, 24'h000000},
            {3'h6, 3'h2, 24'h100000}, {3'h7, 3'h2, 24'h000000}, {3'h4, 3'h0, 24'h100000},
            {3'h4, 3'h1, 24'h180000}, {3'h4, 3'h4, 24'h7fffff}, {3'h2, 3'h6, 24'h800000}};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    frame(16'h0000);
    chk(rd[15:0], ACM_CFG_RESET, "reset settings");
    chk(rd[47:24], 24'h0, "reset result");
    chk(awake, 1'b0, "idle after reset");
    chk(pull_up_en, 1'b1, "pull-up default");
    frame(cfg(1'b0, ACM_MUX_S0, 3'h2, 1'b1, 3'h7) & 16'hfff9);
    frame(cfg(1'b0, ACM_MUX_S0, 3'h2, 1'b1, 3'h7));
    chk(rd[15:0], ACM_CFG_RESET, "bad write code refused");
    frame(16'h0000);
    chk(rd[15:0], cfg(1'b0, ACM_MUX_S0, 3'h2, 1'b1, 3'h7), "write while off");
    chk(awake, 1'b0, "no start without trigger");
    $display("test reset and writes done");

    // short single conversions at the fastest rate, as a duty-cycling host would
    frame(cfg(1'b1, ACM_MUX_S0, 3'h2, 1'b1, 3'h7));
    repeat (2600) @(posedge clk);
    frame(cfg(1'b1, ACM_MUX_S0, 3'h1, 1'b1, 3'h7));
    wait_done(n);
    frame(16'h0000);
    chk(rd[47:24], 24'h300000, "old gain kept in flight");
    chk(rd[15:0], cfg(1'b0, ACM_MUX_S0, 3'h1, 1'b1, 3'h7), "trigger cleared");
    chk(rdy, 1'b0, "ready low on new result");
    repeat (300) @(posedge clk);
    #1;
    chk(awake, 1'b0, "retrigger in flight ignored");
    frame(16'h0000);
    chk(rdy, 1'b1, "ready cleared by read");
    $display("test single shot done");

    for (int i = 0; i < 12; i++) begin
      frame(cfg(1'b1, tbl[i][29:27], tbl[i][26:24], 1'b1, 3'(5 + i % 3)));
      wait_done(n);
      ex = int'(ACM_WAKE_CYC + ACM_CONV_TICKS[5 + i % 3] * ACM_CLK_KHZ / STEP);
      chk(24'(n > ex - 8 && n < ex + 8), 24'h1, "wake plus conversion time");
      frame(16'h0000);
      chk(rd[47:24], tbl[i][23:0], "result code");
    end
    $display("test select gain rate done");

    frame(cfg(1'b0, ACM_MUX_S0, 3'h2, 1'b0, 3'h7));
    repeat (3500) @(posedge clk);
    frame(16'h0000);
    chk(rd[47:24], 24'h300000, "continuous result");
    @(posedge clk);
    a1 <= 24'd384000;
    repeat (1700) @(posedge clk);
    frame(16'h0000);
    chk(rd[47:24], 24'h180000, "continuous next result");
    chk(awake, 1'b1, "still converting");
    frame(cfg(1'b0, ACM_MUX_S0, 3'h2, 1'b1, 3'h7));
    wait_done(n);
    chk(awake, 1'b0, "continuous ended");
    $display("test continuous done");
    wrap_up;
  end
endmodule
